// File: hdl/splw_top.sv
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "splw_consts.svh"
module splw_top #(
   parameter int unsigned P_TICK_CYCLES = `SPLW_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_arst_n,
   // Avalon-MM slave
   input  wire logic [17:0]                i_avs_address,
   input  wire logic                       i_avs_read,
   input  wire logic                       i_avs_write,
   input  wire logic [31:0]                i_avs_writedata,
   input  wire logic [3:0]                 i_avs_byteenable,
   output logic [31:0]                     o_avs_readdata,
   output logic                            o_avs_waitrequest,
   // Link state of ports 4 and 5
   input  wire splw_pkg::splw_link_state_t i_link_state_p4,
   input  wire splw_pkg::splw_link_state_t i_link_state_p5,
   // Split power outputs
   output logic                            o_superspeed_split_power_out_p4,
   output logic                            o_superspeed_split_power_out_p5
);
   import splw_pkg::*;

   // -----------------------------------------------
   // Reset release
   // -----------------------------------------------
   logic rst_meta_reg;   // First stage
   logic rst_n_reg;      // Released copy

   // Release reset through two flops
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // -----------------------------------------------
   // Helpers
   // -----------------------------------------------
   // Word hit on a register index
   function automatic logic reg_hit(input logic [17:0] addr,
                                    input logic [15:0] idx);
      reg_hit = (addr[1:0] == 2'h0) && (addr[17:2] == idx);
   endfunction

   // -----------------------------------------------
   // Registers
   // -----------------------------------------------
   logic [7:0]  split_en_reg;      // superspeed_split_enable_reg
   logic [7:0]  split_en_next;
   logic [2:0]  timeout_reg;       // split_link_timeout_cfg
   logic [2:0]  timeout_next;
   logic [7:0]  toggle_reg;        // split_power_pulse_cfg
   logic [7:0]  toggle_next;
   logic        ack_reg;           // Answer cycle
   logic [31:0] rdata_next;        // Read data to latch
   logic        pulsing_p4;        // Port 4 recovering
   logic        pulsing_p5;        // Port 5 recovering

   // -----------------------------------------------
   // Bus decode
   // -----------------------------------------------
   wire req        = i_avs_read || i_avs_write;
   wire hit_en     = reg_hit(i_avs_address, `SPLW_IDX_SPLIT_EN);
   wire hit_to     = reg_hit(i_avs_address, `SPLW_IDX_TIMEOUT);
   wire hit_tg     = reg_hit(i_avs_address, `SPLW_IDX_TOGGLE);
   wire hit_st     = reg_hit(i_avs_address, `SPLW_IDX_STATUS);
   // Write lands on the answer cycle, low lane only
   wire wr_fire    = i_avs_write && ack_reg && i_avs_byteenable[0];
   // Read data latched on the first request cycle
   wire rd_take    = i_avs_read && !ack_reg;
   wire en_p4      = split_en_reg[`SPLW_EN_P4_BIT]; // RULE10
   wire en_p5      = split_en_reg[`SPLW_EN_P5_BIT]; // RULE10

   // Status word: pulse flags and power levels
   wire [31:0] status_word = {28'h0,
                              o_superspeed_split_power_out_p5,
                              o_superspeed_split_power_out_p4,
                              pulsing_p5,
                              pulsing_p4};

   // Waitrequest drops one cycle after a request
   assign o_avs_waitrequest = req && !ack_reg;

   // Register next values and read mux
   always_comb begin
      split_en_next = split_en_reg;
      timeout_next  = timeout_reg;
      toggle_next   = toggle_reg;
      // Only ports 4 and 5 can be split
      if (wr_fire && hit_en) begin
         split_en_next = i_avs_writedata[7:0] & `SPLW_EN_MASK; // RULE10
      end
      // Upper timeout bits are not stored
      if (wr_fire && hit_to) begin
         timeout_next = i_avs_writedata[2:0]; // RULE2
      end
      // Toggle time feeds only the pulse length
      if (wr_fire && hit_tg) begin
         toggle_next = i_avs_writedata[7:0]; // RULE8
      end
      // Read selection, unmapped reads zero
      if (hit_en) begin
         rdata_next = {24'h0, split_en_reg};
      end else if (hit_to) begin
         rdata_next = {29'h0, timeout_reg};
      end else if (hit_tg) begin
         rdata_next = {24'h0, toggle_reg};
      end else if (hit_st) begin
         rdata_next = status_word;
      end else begin
         rdata_next = 32'h0;
      end
   end

   // Register file and bus answer
   always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         split_en_reg   <= `SPLW_RST_SPLIT_EN;
         timeout_reg    <= `SPLW_RST_TIMEOUT;
         toggle_reg     <= `SPLW_RST_TOGGLE;
         ack_reg        <= 1'b0;
         o_avs_readdata <= 32'h0;
      end else begin
         split_en_reg   <= split_en_next;
         timeout_reg    <= timeout_next;
         toggle_reg     <= toggle_next;
         ack_reg        <= req && !ack_reg;
         if (rd_take) begin
            o_avs_readdata <= rdata_next;
         end
      end
   end

   // -----------------------------------------------
   // Per-port watchdogs
   // -----------------------------------------------
   // Port 4 watchdog
   splw_port_timer #(
      .P_TICK_CYCLES (P_TICK_CYCLES)
   ) u_port4 (
      .i_clk_sys     (i_clk_sys),
      .i_rst_n       (rst_n_reg),
      .i_enable      (en_p4),
      .i_timeout_sel (timeout_reg),
      .i_toggle_time (toggle_reg),
      .i_link_state  (i_link_state_p4),
      .o_power       (o_superspeed_split_power_out_p4),
      .o_pulsing     (pulsing_p4)
   );

   // Port 5 watchdog
   splw_port_timer #(
      .P_TICK_CYCLES (P_TICK_CYCLES)
   ) u_port5 (
      .i_clk_sys     (i_clk_sys),
      .i_rst_n       (rst_n_reg),
      .i_enable      (en_p5),
      .i_timeout_sel (timeout_reg),
      .i_toggle_time (toggle_reg),
      .i_link_state  (i_link_state_p5),
      .o_power       (o_superspeed_split_power_out_p5),
      .o_pulsing     (pulsing_p5)
   );

   // -----------------------------------------------
   // Checks
   // -----------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!rst_n_reg);

   // A fresh request sees waitrequest high
   sequence s_new_req;
      req && !ack_reg;
   endsequence

   // Then the answer arrives next cycle
   sequence s_answer;
      !o_avs_waitrequest;
   endsequence

   property p_bus_answer;
      s_new_req |=> s_answer;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("bus answer late");

   property p_en_mask;
      (split_en_reg & ~`SPLW_EN_MASK) == 8'h00;
   endproperty
   a_en_mask: assert property (p_en_mask) // RULE10
      else $error("split enable outside ports 4 and 5");

   property p_en_write;
      wr_fire && hit_en |=>
         split_en_reg == ($past(i_avs_writedata[7:0]) & `SPLW_EN_MASK);
   endproperty
   a_en_write: assert property (p_en_write) // RULE10
      else $error("split enable write lost");

   property p_toggle_write;
      wr_fire && hit_tg |=> toggle_reg == $past(i_avs_writedata[7:0]);
   endproperty
   a_toggle_write: assert property (p_toggle_write) // RULE8
      else $error("toggle time write lost");

   property p_timeout_read;
      rd_take && hit_to |=> o_avs_readdata == {29'h0, $past(timeout_reg)};
   endproperty
   a_timeout_read: assert property (p_timeout_read) // RULE2
      else $error("timeout read wrong or reserved bits set");

   property p_p4_off_idle;
      !en_p4 |=> o_superspeed_split_power_out_p4;
   endproperty
   a_p4_off_idle: assert property (p_p4_off_idle) // RULE12
      else $error("port 4 pulsed while not split");

   property p_p5_off_idle;
      !en_p5 |=> o_superspeed_split_power_out_p5;
   endproperty
   a_p5_off_idle: assert property (p_p5_off_idle) // RULE12
      else $error("port 5 pulsed while not split");

   property p_low_means_pulse;
      !o_superspeed_split_power_out_p4 |-> pulsing_p4;
   endproperty
   a_low_means_pulse: assert property (p_low_means_pulse) // RULE11
      else $error("port 4 power low outside pulse");
endmodule
`default_nettype wire

// File: hdl/splw_consts.svh
`ifndef SPLW_CONSTS_SVH
`define SPLW_CONSTS_SVH
// Summary of operation
// [RULE1] Stuck link for full timeout pulses power
// [RULE2] Timeout codes 1..6 map 100ms..2s
// [RULE3] Timeout code zero never pulses power
// [RULE4] Expiry clears and restarts timeout counter
// [RULE5] Toggle field zero gives 350ms pulse
// [RULE6] Each toggle step adds 10ms
// [RULE7] Pulse counter cleared when toggle finishes
// [RULE8] Toggle time shapes only recovery pulse
// [RULE9] Invalid means one state 0x4..0x9 throughout
// [RULE10] Split only ports 4,5 via bits 5,6
// [RULE11] Power low during pulse, high otherwise
// [RULE12] Per-port counters run only when enabled

// -----------------------------------------------
// Register indices (byte address is four times)
// -----------------------------------------------
`define SPLW_IDX_SPLIT_EN 16'h3c48
`define SPLW_IDX_TIMEOUT  16'h4171
`define SPLW_IDX_TOGGLE   16'h4176
`define SPLW_IDX_STATUS   16'h4177

// -----------------------------------------------
// Reset values and fields
// -----------------------------------------------
`define SPLW_RST_SPLIT_EN 8'h00
`define SPLW_RST_TIMEOUT  3'h5
`define SPLW_RST_TOGGLE   8'h05
`define SPLW_EN_MASK      8'h60
`define SPLW_EN_P4_BIT    5
`define SPLW_EN_P5_BIT    6
`define SPLW_LS_FIRST_BAD 4'h4
`define SPLW_LS_LAST_BAD  4'h9

// -----------------------------------------------
// Timing
// -----------------------------------------------
`define SPLW_CLK_KHZ       125000
`define SPLW_TICK_MS       10
`define SPLW_TICK_CYCLES   (`SPLW_TICK_MS * `SPLW_CLK_KHZ)
`define SPLW_TO1_MS        100
`define SPLW_TO2_MS        250
`define SPLW_TO3_MS        500
`define SPLW_TO4_MS        750
`define SPLW_TO5_MS        1000
`define SPLW_TO6_MS        2000
`define SPLW_PULSE_MIN_MS  350
`define SPLW_PULSE_STEP_MS 10
`endif

// File: hdl/splw_pkg.sv
package splw_pkg;
   // Recovery sequencer state of one port
   typedef enum logic [0:0] {
      SPLW_ST_WATCH = 1'b0,
      SPLW_ST_PULSE = 1'b1
   } splw_state_t;
   // Link training state code of one port
   typedef logic [3:0] splw_link_state_t;
endpackage

// File: hdl/splw_port_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "splw_consts.svh"
module splw_port_timer #(
   parameter int unsigned P_TICK_CYCLES = `SPLW_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_rst_n,
   // Configuration
   input  wire logic                       i_enable,
   input  wire logic [2:0]                 i_timeout_sel,
   input  wire logic [7:0]                 i_toggle_time,
   // Link status, same clock domain
   input  wire splw_pkg::splw_link_state_t i_link_state,
   // Power control and status
   output logic                            o_power,
   output logic                            o_pulsing
);
   import splw_pkg::*;

   // -----------------------------------------------
   // Timing helpers
   // -----------------------------------------------
   // Timeout code to ten-millisecond ticks
   function automatic logic [8:0] to_ticks(input logic [2:0] sel);
      case (sel)
         3'h1:    to_ticks = 9'(`SPLW_TO1_MS / `SPLW_TICK_MS); // RULE2
         3'h2:    to_ticks = 9'(`SPLW_TO2_MS / `SPLW_TICK_MS);
         3'h3:    to_ticks = 9'(`SPLW_TO3_MS / `SPLW_TICK_MS);
         3'h4:    to_ticks = 9'(`SPLW_TO4_MS / `SPLW_TICK_MS);
         3'h5:    to_ticks = 9'(`SPLW_TO5_MS / `SPLW_TICK_MS);
         3'h6:    to_ticks = 9'(`SPLW_TO6_MS / `SPLW_TICK_MS);
         default: to_ticks = 9'h000; // RULE3
      endcase
   endfunction

   splw_state_t state_reg, state_next;   // Sequencer
   logic [31:0] cyc_reg, cyc_next;       // Cycles within tick
   logic [8:0]  tick_reg, tick_next;     // Ticks elapsed
   logic [3:0]  last_reg;                // Previous link state
   logic [31:0] low_reg;                 // Checker: low cycles

   // -----------------------------------------------
   // Decode
   // -----------------------------------------------
   wire       bad_state  = (i_link_state >= `SPLW_LS_FIRST_BAD) &&
                           (i_link_state <= `SPLW_LS_LAST_BAD); // RULE9
   wire       same_state = (i_link_state == last_reg); // RULE9
   wire [8:0] limit      = to_ticks(i_timeout_sel);
   wire [8:0] pulse_len  = 9'(`SPLW_PULSE_MIN_MS / `SPLW_TICK_MS) +
                           9'(i_toggle_time); // RULE5 RULE6 RULE8
   wire       watch_on   = i_enable && (limit != 9'h000) &&
                           bad_state && same_state; // RULE1 RULE3
   wire       tick_wrap  = (cyc_reg == P_TICK_CYCLES - 32'd1);
   wire [8:0] tick_inc   = tick_reg + 9'h001;
   wire       in_pulse   = (state_reg == SPLW_ST_PULSE);
   wire       fire       = !in_pulse && watch_on && tick_wrap &&
                           (tick_inc == limit); // RULE1
   wire       done       = in_pulse && tick_wrap &&
                           (tick_inc == pulse_len); // RULE8
   wire       run        = in_pulse ? i_enable : watch_on; // RULE12
   wire       clear      = !run || fire || done; // RULE4 RULE7

   // Next state and counters
   always_comb begin
      cyc_next  = clear ? 32'h0 : (tick_wrap ? 32'h0 : cyc_reg + 32'h1);
      tick_next = clear ? 9'h000 : (tick_wrap ? tick_inc : tick_reg);
      if (!i_enable) begin
         state_next = SPLW_ST_WATCH; // RULE12
      end else if (fire) begin
         state_next = SPLW_ST_PULSE; // RULE1
      end else if (done) begin
         state_next = SPLW_ST_WATCH;
      end else begin
         state_next = state_reg;
      end
   end

   // Registers, power output comes from a flip-flop
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= SPLW_ST_WATCH;
         cyc_reg   <= 32'h0;
         tick_reg  <= 9'h000;
         last_reg  <= 4'h0;
         o_power   <= 1'b1;
         o_pulsing <= 1'b0;
         low_reg   <= 32'h0;
      end else begin
         state_reg <= state_next;
         cyc_reg   <= cyc_next;
         tick_reg  <= tick_next;
         last_reg  <= i_link_state;
         o_power   <= (state_next != SPLW_ST_PULSE); // RULE11
         o_pulsing <= (state_next == SPLW_ST_PULSE);
         low_reg   <= o_power ? 32'h0 : low_reg + 32'h1;
      end
   end

   // -----------------------------------------------
   // Checks
   // -----------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   property p_fall_needs_cause;
      $fell(o_power) |-> $past(i_enable) && $past(bad_state) &&
         ($past(i_timeout_sel) != 3'h0);
   endproperty
   a_fall_needs_cause: assert property (p_fall_needs_cause) // RULE1
      else $error("power pulse without stuck link");

   property p_code0_quiet;
      (i_timeout_sel == 3'h0) && o_power && !in_pulse |=> o_power;
   endproperty
   a_code0_quiet: assert property (p_code0_quiet) // RULE3
      else $error("power pulsed with timeout disabled");

   property p_restart;
      $fell(o_power) |-> (cyc_reg == 32'h0) && (tick_reg == 9'h000);
   endproperty
   a_restart: assert property (p_restart) // RULE4
      else $error("timeout counter not cleared on expiry");

   property p_pulse_len;
      $rose(o_power) && $past(i_enable) |->
         $past(low_reg) + 32'h1 == 32'(pulse_len) * P_TICK_CYCLES;
   endproperty
   a_pulse_len: assert property (p_pulse_len) // RULE5
      else $error("recovery pulse length wrong");

   property p_pulse_done_clear;
      $rose(o_power) |-> (cyc_reg == 32'h0) && (tick_reg == 9'h000);
   endproperty
   a_pulse_done_clear: assert property (p_pulse_done_clear) // RULE7
      else $error("pulse counter not cleared at end");

   property p_valid_link_no_fall;
      !bad_state && o_power |=> o_power;
   endproperty
   a_valid_link_no_fall: assert property (p_valid_link_no_fall) // RULE9
      else $error("pulse although link state valid");

   property p_disabled_idle;
      !i_enable |=> o_power && (tick_reg == 9'h000) && (cyc_reg == 32'h0);
   endproperty
   a_disabled_idle: assert property (p_disabled_idle) // RULE12
      else $error("disabled port not idle");

   property p_pulse_matches_state;
      o_power == !in_pulse;
   endproperty
   a_pulse_matches_state: assert property (p_pulse_matches_state) // RULE11
      else $error("power output disagrees with state");
endmodule
`default_nettype wire

// File: testbench/splw_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Embedded device behind the split power switch of one port
// ------------------------------------------------------------
module splw_dev_model (
   // Clock
   input  wire logic       i_clk_sys,
   // Power switch driven by the hub
   input  wire logic       i_power,
   // Scenario: 0 trained, 1 stuck on i_code, 2 fast walk, 3 slow walk
   input  wire logic [1:0] i_mode,
   input  wire logic [3:0] i_code,
   // Link training state reported to the hub
   output logic      [3:0] o_link_state
);
   int unsigned dwell;  // Cycles spent in the present walk state

   initial begin
      o_link_state = 4'h0;
      dwell = 0;
   end

   // ------------------------------------------------------------
   // Link state sequencing
   // ------------------------------------------------------------
   // An unpowered device can only sit in receiver detect
   always @(posedge i_clk_sys) begin
      dwell <= dwell + 1;
      if (i_power !== 1'b1) begin
         o_link_state <= 4'h5;
      end else if (i_mode == 2'd0) begin
         o_link_state <= 4'h0;
      end else if (i_mode == 2'd1) begin
         o_link_state <= i_code;
      end else if (i_mode == 2'd2 || dwell >= 30) begin
         // Walking through training states, each shorter than any timeout
         o_link_state <= (o_link_state < 4'h4 || o_link_state >= 4'h9) ? 4'h4 : o_link_state + 4'h1;
         dwell <= 0;
      end
   end
endmodule
`default_nettype wire

// File: testbench/split_port_link_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "splw_consts.svh"
`define CHK_EQ(got, exp) begin checks_done++; if ((got) !== (exp)) begin failures++; \
   $display("Error at %0t: got %0h, expected %0h", $time, got, exp); end end
module split_port_link_watchdog_tb;
   import splw_pkg::*;
   // ------------------------------------------------------------
   // Settings and signals
   // ------------------------------------------------------------
   localparam int unsigned TICK = 4;  // Cycles per 10 ms tick, shortened
   localparam logic [17:0] A_EN = {`SPLW_IDX_SPLIT_EN, 2'b00};
   localparam logic [17:0] A_TO = {`SPLW_IDX_TIMEOUT, 2'b00};
   localparam logic [17:0] A_TG = {`SPLW_IDX_TOGGLE, 2'b00};
   localparam logic [17:0] A_ST = {`SPLW_IDX_STATUS, 2'b00};
   logic             clk = 1'b0;    // System clock
   logic             arst_n = 1'b0; // Asynchronous reset
   logic      [17:0] addr = '0;     // Bus address
   logic             rd = 1'b0;     // Bus read
   logic             wr = 1'b0;     // Bus write
   logic      [31:0] wdata = '0;    // Bus write data
   logic      [ 3:0] be = 4'hf;     // Byte enables
   logic      [31:0] rdata;         // Bus read data
   logic             waitreq;       // Bus wait
   logic             pw4;           // Port 4 split power
   logic             pw5;           // Port 5 split power
   splw_link_state_t ls4;           // Port 4 link state
   splw_link_state_t ls5;           // Port 5 link state
   logic      [ 1:0] mode4 = '0;    // Port 4 device behaviour
   logic      [ 1:0] mode5 = '0;    // Port 5 device behaviour
   logic      [ 3:0] code4 = 4'h5;  // Port 4 stuck state
   logic      [ 3:0] code5 = 4'h5;  // Port 5 stuck state
   int               failures = 0;
   int               checks_done = 0;

   always #4 clk = ~clk;

   // ------------------------------------------------------------
   // Design and device models
   // ------------------------------------------------------------
   splw_top #(.P_TICK_CYCLES(TICK)) u_splw_top (
      .i_clk_sys(clk), .i_arst_n(arst_n),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
      .i_link_state_p4(ls4), .i_link_state_p5(ls5),
      .o_superspeed_split_power_out_p4(pw4), .o_superspeed_split_power_out_p5(pw5));
   splw_dev_model u_splw_dev_model_p4 (
      .i_clk_sys(clk), .i_power(pw4), .i_mode(mode4), .i_code(code4), .o_link_state(ls4));
   splw_dev_model u_splw_dev_model_p5 (
      .i_clk_sys(clk), .i_power(pw5), .i_mode(mode5), .i_code(code5), .o_link_state(ls5));

   // ------------------------------------------------------------
   // Bus and measurement helpers
   // ------------------------------------------------------------
   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d, output logic [31:0] q);
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= {24'h0, d};
      // Answer and read data are taken at the rising edge that sees waitrequest low
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [17:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      `CHK_EQ(q, e)
   endtask

   task automatic wr_reg(input logic [17:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   function automatic logic pwr(input int p);
      return (p == 5) ? pw5 : pw4;
   endfunction

   // Expected timeout in cycles for a selector code; zero when disabled
   function automatic int to_cyc(input logic [2:0] c);
      int ms[8] = '{0, 100, 250, 500, 750, 1000, 2000, 0};
      return ms[c] / 10 * TICK;
   endfunction

   // Cycles until power falls, cycles it stays low, other port low before the fall
   task automatic measure(input int p, input int lim, output int t, output int len, output logic oth);
      t = 0;
      len = 0;
      oth = 1'b0;
      while (t < lim && len == 0) begin
         @(negedge clk);
         t++;
         oth |= (pwr(9 - p) === 1'b0);
         if (pwr(p) === 1'b0) len = 1;
      end
      while (len > 0 && pwr(p) === 1'b0 && len < 4000) begin
         @(negedge clk);
         if (pwr(p) === 1'b0) len++;
      end
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Stuck link on one port, other port disabled but also stuck
   task automatic run_stuck(input int p, input logic [2:0] c, input logic [7:0] tg);
      int t, len, e;
      logic oth;
      wr_reg(A_EN, (p == 5) ? 8'h40 : 8'h20);
      wr_reg(A_TO, {5'h0, c});
      wr_reg(A_TG, tg);
      e = to_cyc(c);
      mode4 <= 2'd1;
      mode5 <= 2'd1;
      code4 <= 4'h4 + 4'($urandom_range(5));
      code5 <= 4'h4 + 4'($urandom_range(5));
      measure(p, e + 50, t, len, oth);
      `CHK_EQ(t >= e && t <= e + 5, 1'b1)
      `CHK_EQ(len, (35 + tg) * TICK)
      `CHK_EQ(oth, 1'b0)
      measure(p, e + 50, t, len, oth);
      `CHK_EQ(t >= e - 2 && t <= e + 5, 1'b1)
      `CHK_EQ(len, (35 + tg) * TICK)
      mode4 <= 2'd0;
      mode5 <= 2'd0;
      wr_reg(A_EN, 8'h00);
   endtask

   // Both ports enabled for a long stretch without any pulse allowed
   task automatic quiet(input logic [2:0] c, input logic [1:0] m);
      int t, len;
      logic oth;
      wr_reg(A_TO, {5'h0, c});
      wr_reg(A_EN, 8'h60);
      mode4 <= m;
      mode5 <= m;
      measure(4, 900, t, len, oth);
      `CHK_EQ({len, oth}, 33'h0)
      mode4 <= 2'd0;
      mode5 <= 2'd0;
      wr_reg(A_EN, 8'h00);
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Budget well above the roughly 13k cycles the scenarios need
   initial begin
      repeat (40000) @(posedge clk);
      failures++;
      summarize();
   end

   initial begin
      logic [7:0] tg;
      int i, t, len;
      logic oth;
      void'($urandom(32'hc3e672d4));
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      // Reset values, masking and refused addresses
      rd_chk(A_EN, 32'h0);
      rd_chk(A_TO, 32'h5);
      rd_chk(A_TG, 32'h5);
      rd_chk(A_ST, 32'hc);
      rd_chk(18'h00010, 32'h0);
      rd_chk(A_TO + 18'h1, 32'h0);
      wr_reg(A_EN, 8'hff);
      rd_chk(A_EN, 32'h60);
      wr_reg(A_TO, 8'hff);
      rd_chk(A_TO, 32'h7);
      // Write with the low byte lane off is ignored
      be <= 4'h0;
      wr_reg(A_TG, 8'h77);
      be <= 4'hf;
      rd_chk(A_TG, 32'h5);
      wr_reg(A_EN, 8'h00);
      // Timeout codes 1 to 6, alternating ports, corner toggle values
      for (int c = 1; c <= 6; c++) begin
         tg = (c == 1) ? 8'h00 : (c == 6) ? 8'hff : 8'($urandom_range(20));
         run_stuck((c % 2) ? 4 : 5, c[2:0], tg);
      end
      quiet(3'd0, 2'd1);
      quiet(3'd7, 2'd1);
      quiet(3'd1, 2'd2);
      quiet(3'd1, 2'd3);
      quiet(3'd1, 2'd0);
      // Disable in mid pulse, then a fresh full timeout
      wr_reg(A_TO, 8'h01);
      wr_reg(A_TG, 8'h30);
      wr_reg(A_EN, 8'h20);
      mode4 <= 2'd1;
      i = 0;
      while (pw4 !== 1'b0 && i < 200) begin
         @(negedge clk);
         i++;
      end
      rd_chk(A_ST, 32'h9);
      wr_reg(A_EN, 8'h00);
      repeat (2) @(negedge clk);
      `CHK_EQ(pw4, 1'b1)
      wr_reg(A_EN, 8'h20);
      measure(4, 200, t, len, oth);
      `CHK_EQ(t >= to_cyc(3'd1) - 2 && t <= to_cyc(3'd1) + 5, 1'b1)
      `CHK_EQ(len, (35 + 8'h30) * TICK)
      mode4 <= 2'd0;
      wr_reg(A_EN, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
